// file: design/scb_pkg.sv
/*
 * Constants shared by the stage 1 context bank register block: byte offsets
 * inside the 4 KB bank page, field positions and reset values.
 * Assumes the bank page is decoded by the interconnect; offsets are local.
 */
`default_nettype none

package scb_pkg;

	// ********************************************************
	// bus shape
	// ********************************************************
	localparam int DATA_W = 32;
	localparam int WADDR_W = 10;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ********************************************************
	// byte offsets
	// ********************************************************
	localparam logic [11:0] OFF_TLB_STATUS = 12'h7F4;
	localparam logic [11:0] OFF_ATS_PRIV_RD = 12'h800;
	localparam logic [11:0] OFF_ATS_PRIV_WR = 12'h808;
	localparam logic [11:0] OFF_ATS_USER_RD = 12'h810;
	localparam logic [11:0] OFF_ATS_USER_WR = 12'h818;
	localparam logic [11:0] OFF_ATS_STATUS = 12'h8F0;
	localparam logic [11:0] OFF_IMPDEF_BASE = 12'hD00;
	localparam logic [11:0] OFF_CTX_CTRL = 12'hDFC;
	localparam logic [11:0] OFF_EVCNT_BASE = 12'hE00;
	localparam logic [11:0] OFF_EVSEL_BASE = 12'hE80;
	localparam logic [11:0] OFF_PM_CFG = 12'hF00;
	localparam logic [11:0] OFF_PM_CTRL = 12'hF04;
	localparam logic [11:0] OFF_PM_USER_SLOT = 12'hF08;
	localparam logic [11:0] OFF_PM_CEID_LO = 12'hF20;
	localparam logic [11:0] OFF_PM_CEID_HI = 12'hF24;
	localparam logic [11:0] OFF_CNTEN_SET = 12'hF40;
	localparam logic [11:0] OFF_CNTEN_CLR = 12'hF44;
	localparam logic [11:0] OFF_INTEN_SET = 12'hF48;
	localparam logic [11:0] OFF_INTEN_CLR = 12'hF4C;
	localparam logic [11:0] OFF_OVS_CLR = 12'hF50;
	localparam logic [11:0] OFF_PM_SWINC_SLOT = 12'hF54;
	localparam logic [11:0] OFF_OVS_SET = 12'hF58;
	localparam logic [11:0] OFF_PM_AUTH = 12'hFB8;
	localparam logic [11:0] OFF_PM_DEVTYPE_SLOT = 12'hFCC;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int TLB_ACTIVE_BIT = 0;
	localparam int ATS_ACTIVE_BIT = 0;
	localparam int CTX_IRQ_EN_BIT = 0;
	localparam int CTX_REPORT_EN_BIT = 1;
	localparam int CTX_STALL_BIT = 2;
	localparam int PM_CTRL_EN_BIT = 0;
	localparam int PM_CTRL_CLR_BIT = 1;
	localparam int CFG_N_LSB = 0;
	localparam int CFG_SIZE_LSB = 8;
	localparam logic [5:0] CFG_SIZE_VAL = 6'h1F;

	// ********************************************************
	// translation operation kinds, in offset order
	// ********************************************************
	typedef enum logic [1:0] {
		ATS_PRIV_RD,
		ATS_PRIV_WR,
		ATS_USER_RD,
		ATS_USER_WR
	} scb_ats_kind_t;

endpackage

`default_nettype wire

// file: design/scb_pmu_if.sv
/*
 * Carrier between the bank register file and its event counter array.
 * Assumes both ends share sys_clk; all signals are sampled on it.
 */
`default_nettype none

interface scb_pmu_if #(
	parameter int N = 15
);
	logic [N-1:0] inc;
	logic [N-1:0] wr;
	logic [31:0] wdata;
	logic clr_all;
	logic [N-1:0][31:0] cnt;
	logic [N-1:0] ovf;

	modport bank (output inc, output wr, output wdata, output clr_all, input cnt, input ovf);
	modport counters (input inc, input wr, input wdata, input clr_all, output cnt, output ovf);
endinterface

`default_nettype wire

// file: design/scb_pmu_counters.sv
/*
 * Array of 32-bit event counters with software write and wrap pulse.
 * Assumes the bank drives at most one write per counter per cycle.
 */
`default_nettype none

module scb_pmu_counters
	import scb_pkg::*;
#(
	parameter int N = 15
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// bank side
	scb_pmu_if.counters pif
);
	typedef struct packed {
		logic [N-1:0][31:0] cnt;
		logic [N-1:0] ovf;
	} scb_cnt_state_t;

	scb_cnt_state_t q;
	scb_cnt_state_t d;
	logic [N-1:0][31:0] nxt;
	logic [N-1:0] wrap;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++)
		begin : g_cnt
			// software write beats a same-cycle increment
			assign nxt[gi] = pif.clr_all ? RST_WORD :
				pif.wr[gi] ? pif.wdata :
				pif.inc[gi] ? q.cnt[gi] + 32'h0000_0001 : q.cnt[gi];
			assign wrap[gi] = ~pif.clr_all & ~pif.wr[gi] & pif.inc[gi] & (&q.cnt[gi]);
		end
	endgenerate

	always_comb
	begin
		d = q;
		d.cnt = nxt;
		d.ovf = wrap;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign pif.cnt = q.cnt;
	assign pif.ovf = q.ovf;
endmodule

`default_nettype wire

// file: design/scb_bank.sv
/*
 * Upper register map of one stage 1 translation context bank: TLB status,
 * address translation operations and status, an implementation window and
 * the per-bank performance monitor, behind an Avalon-MM slave.
 * Assumes a word-addressed Avalon master on sys_clk, a translation engine
 * that pulses ats_done, and event inputs synchronous to sys_clk.
 */
// Functional notes
// - other bank fields may reset undefined
// - reset clears translation status to zero
// - reset clears the stalled fault flag
// - reset clears context fault interrupt enable
// - reset clears context fault report enable
// - reset clears TLB maintenance status
// - 0xD00-0xDF8 is free read/write space; 0xDFC holds context fault control
// - monitor user/increment/type slots stay unimplemented
`default_nettype none

module scb_bank
	import scb_pkg::*;
#(
	parameter int N_CNT = 15,
	parameter int EVT_W = 8,
	parameter int SEL_W = 8,
	parameter logic [31:0] CEID_LO = 32'h0000_0000,
	parameter logic [31:0] CEID_HI = 32'h0000_0000,
	parameter logic [31:0] AUTH_VAL = 32'h0000_0000
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// avalon-mm slave, word addressed
	input wire logic [WADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// translation engine
	output logic ats_req,
	output scb_ats_kind_t ats_kind,
	output logic [63:0] ats_addr,
	input wire logic ats_done,
	// tlb maintenance
	input wire logic tlb_sync_busy,
	// context fault control
	input wire logic fault_stall_set,
	output logic ctx_fault_irq_enable,
	output logic ctx_fault_report_enable,
	output logic fault_stalled_flag,
	// performance monitor
	input wire logic [EVT_W-1:0] pmu_events,
	output logic pmu_irq
);
	localparam int IMPDEF_WORDS = 63;

	// ********************************************************
	// state
	// ********************************************************
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic tlb_active;
		logic ats_active;
		logic ats_req;
		scb_ats_kind_t ats_kind;
		logic [63:0] ats_addr;
		logic [IMPDEF_WORDS-1:0][31:0] impdef;
		logic irq_en;
		logic report_en;
		logic stalled;
		logic pm_en;
		logic [N_CNT-1:0] cnten;
		logic [N_CNT-1:0] inten;
		logic [N_CNT-1:0] ovs;
		logic [N_CNT-1:0][SEL_W-1:0] evsel;
	} scb_bank_state_t;

	scb_bank_state_t q;
	scb_bank_state_t d;

	scb_pmu_if #(.N(N_CNT)) pif ();

	scb_pmu_counters #(.N(N_CNT)) u_counters (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pif(pif)
	);

	// ********************************************************
	// bus decode
	// ********************************************************
	logic [11:0] addr_b;
	logic req;
	logic take;
	logic wr_fire;
	logic [3:0] slot;
	logic in_cnt;
	logic in_sel;
	logic in_impdef;
	logic slot_ok;
	logic [31:0] be_mask;

	assign addr_b = {avs_address, 2'b00};
	assign req = avs_read | avs_write;
	// one wait cycle: lets readdata come straight from a flop
	assign take = req & ~q.ack;
	assign wr_fire = avs_write & q.ack;
	assign slot = addr_b[5:2];
	assign slot_ok = 32'(slot) < N_CNT;
	assign in_cnt = addr_b[11:6] == OFF_EVCNT_BASE[11:6];
	assign in_sel = addr_b[11:6] == OFF_EVSEL_BASE[11:6];
	assign in_impdef = addr_b[11:8] == OFF_IMPDEF_BASE[11:8];
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// ********************************************************
	// counter hookup
	// ********************************************************
	genvar gi;
	generate
		for (gi = 0; gi < N_CNT; gi++)
		begin : g_evt
			logic [SEL_W-1:0] sel;
			logic hit;
			assign sel = q.evsel[gi];
			// selector beyond the event bus counts nothing
			assign hit = (32'(sel) < EVT_W) ? pmu_events[sel[$clog2(EVT_W)-1:0]] : 1'b0;
			assign pif.inc[gi] = q.pm_en & q.cnten[gi] & hit;
			assign pif.wr[gi] = wr_fire & in_cnt & slot_ok & (slot == 4'(gi));
		end
	endgenerate

	assign pif.wdata = merge(slot_ok ? pif.cnt[slot] : RST_WORD, avs_writedata, be_mask);
	assign pif.clr_all = wr_fire & (addr_b == OFF_PM_CTRL) & avs_writedata[PM_CTRL_CLR_BIT];

	// ********************************************************
	// next state
	// ********************************************************
	always_comb
	begin
		logic [31:0] rd;
		logic [31:0] w1;
		logic [N_CNT-1:0] wmask;
		logic [N_CNT-1:0] ovs_clr;
		logic [N_CNT-1:0] ovs_set;
		logic ss_clr;
		rd = RST_WORD;
		w1 = avs_writedata & be_mask;
		wmask = w1[N_CNT-1:0];
		ovs_clr = '0;
		ovs_set = '0;
		ss_clr = 1'b0;
		d = q;
		d.ack = take;
		d.ats_req = 1'b0;
		d.tlb_active = tlb_sync_busy;

		// read path
		if (in_impdef)
		begin
			if (addr_b == OFF_CTX_CTRL)
			begin
				rd[CTX_IRQ_EN_BIT] = q.irq_en;
				rd[CTX_REPORT_EN_BIT] = q.report_en;
				rd[CTX_STALL_BIT] = q.stalled;
			end
			else
				rd = q.impdef[addr_b[7:2]];
		end
		else if (in_cnt)
		begin
			if (slot_ok)
				rd = pif.cnt[slot];
		end
		else if (in_sel)
		begin
			if (slot_ok)
				rd = 32'(q.evsel[slot]);
		end
		else
		begin
			case (addr_b)
				OFF_TLB_STATUS: rd[TLB_ACTIVE_BIT] = q.tlb_active;
				OFF_ATS_STATUS: rd[ATS_ACTIVE_BIT] = q.ats_active;
				OFF_PM_CFG:
				begin
					rd[CFG_N_LSB +: 8] = 8'(N_CNT - 1);
					rd[CFG_SIZE_LSB +: 6] = CFG_SIZE_VAL;
				end
				OFF_PM_CTRL: rd[PM_CTRL_EN_BIT] = q.pm_en;
				OFF_PM_CEID_LO: rd = CEID_LO;
				OFF_PM_CEID_HI: rd = CEID_HI;
				OFF_CNTEN_SET, OFF_CNTEN_CLR: rd[N_CNT-1:0] = q.cnten;
				OFF_INTEN_SET, OFF_INTEN_CLR: rd[N_CNT-1:0] = q.inten;
				OFF_OVS_CLR, OFF_OVS_SET: rd[N_CNT-1:0] = q.ovs;
				OFF_PM_AUTH: rd = AUTH_VAL;
				OFF_PM_USER_SLOT, OFF_PM_SWINC_SLOT, OFF_PM_DEVTYPE_SLOT: rd = RST_WORD;
				default: rd = RST_WORD;
			endcase
		end
		if (take & avs_read)
			d.rdata = rd;

		// write path: takes effect on the cycle waitrequest is low
		if (wr_fire)
		begin
			if (in_impdef)
			begin
				if (addr_b == OFF_CTX_CTRL)
				begin
					d.irq_en = avs_writedata[CTX_IRQ_EN_BIT];
					d.report_en = avs_writedata[CTX_REPORT_EN_BIT];
					ss_clr = w1[CTX_STALL_BIT];
				end
				else
					d.impdef[addr_b[7:2]] = merge(q.impdef[addr_b[7:2]], avs_writedata,
						be_mask);
			end
			else if (in_sel)
			begin
				if (slot_ok)
					d.evsel[slot] = SEL_W'(merge(32'(q.evsel[slot]), avs_writedata, be_mask));
			end
			else if (!in_cnt)
			begin
				case (addr_b)
					// only the low word starts an operation; it is zero extended
					OFF_ATS_PRIV_RD, OFF_ATS_PRIV_WR, OFF_ATS_USER_RD, OFF_ATS_USER_WR:
					begin
						// a second request while one is in flight is dropped
						if (!q.ats_active)
						begin
							d.ats_active = 1'b1;
							d.ats_req = 1'b1;
							d.ats_kind = scb_ats_kind_t'(addr_b[4:3]);
							d.ats_addr = {32'h0000_0000, avs_writedata};
						end
					end
					OFF_PM_CTRL: d.pm_en = avs_writedata[PM_CTRL_EN_BIT];
					OFF_CNTEN_SET: d.cnten = q.cnten | wmask;
					OFF_CNTEN_CLR: d.cnten = q.cnten & ~wmask;
					OFF_INTEN_SET: d.inten = q.inten | wmask;
					OFF_INTEN_CLR: d.inten = q.inten & ~wmask;
					OFF_OVS_CLR: ovs_clr = wmask;
					OFF_OVS_SET: ovs_set = wmask;
					OFF_PM_USER_SLOT, OFF_PM_SWINC_SLOT, OFF_PM_DEVTYPE_SLOT: ;
					default: ;
				endcase
			end
		end

		// sticky overflow: hardware wrap wins over a same-cycle clear
		d.ovs = (q.ovs & ~ovs_clr) | ovs_set | pif.ovf;

		// translation completes; a new start in the same cycle wins
		if (ats_done & ~d.ats_req)
			d.ats_active = 1'b0;

		// stall flag: fault event wins over software clear
		if (ss_clr)
			d.stalled = 1'b0;
		if (fault_stall_set)
			d.stalled = 1'b1;
	end

	// ********************************************************
	// registers
	// ********************************************************
	// every field is given a value, a legal choice where reset leaves it open
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.ats_active <= 1'b0;
			q.stalled <= 1'b0;
			q.irq_en <= 1'b0;
			q.report_en <= 1'b0;
			q.tlb_active <= 1'b0;
		end
		else
			q <= d;
	end

	// ********************************************************
	// outputs
	// ********************************************************
	assign avs_readdata = q.rdata;
	assign avs_waitrequest = take;
	assign ats_req = q.ats_req;
	assign ats_kind = q.ats_kind;
	assign ats_addr = q.ats_addr;
	assign ctx_fault_irq_enable = q.irq_en;
	assign ctx_fault_report_enable = q.report_en;
	assign fault_stalled_flag = q.stalled;
	assign pmu_irq = |(q.ovs & q.inten);
endmodule

`default_nettype wire

// file: tb/scb_bank_checker.sv
/* port checker for scb_bank: reset values, wait state, ops, reserved reads.
   assumes a bind from the bench top and one clock domain. */
`default_nettype none
module scb_bank_checker
	import scb_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register bus
	input wire logic [WADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	// ops and control
	input wire logic ats_req,
	input wire scb_ats_kind_t ats_kind,
	input wire logic [63:0] ats_addr,
	input wire logic fault_stall_set,
	input wire logic fault_stalled_flag,
	input wire logic ctx_fault_irq_enable,
	input wire logic ctx_fault_report_enable,
	input wire logic pmu_irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	wire logic req;
	wire logic take;
	assign req = avs_read | avs_write;
	assign take = req & ~avs_waitrequest;
	// ********************************************************
	// assertions
	// ********************************************************
	AST_RST_CTX: assert property (sys_rst |=> !ctx_fault_irq_enable &&
		!ctx_fault_report_enable && !fault_stalled_flag) else $error("ctx bits after reset");
	AST_RST_OUT: assert property (sys_rst |=> !pmu_irq && !ats_req)
		else $error("outputs after reset");
	AST_WAIT_FIRST: assert property (disable iff (sys_rst) $rose(req) |-> avs_waitrequest)
		else $error("no wait state");
	AST_WAIT_ONE: assert property (disable iff (sys_rst) req && avs_waitrequest |=> take)
		else $error("wait too long");
	AST_ATS_CAUSE: assert property (disable iff (sys_rst) ats_req |-> $past(take) &&
		$past(avs_write) && $past(avs_address[9:3]) == 7'h40 && !$past(avs_address[0]))
		else $error("op start without write");
	AST_ATS_DATA: assert property (disable iff (sys_rst) ats_req |-> !$past(ats_req) &&
		ats_kind == $past(avs_address[2:1]) && ats_addr == {32'h0, $past(avs_writedata)})
		else $error("op kind or address");
	AST_RSVD_ZERO: assert property (disable iff (sys_rst) take && avs_read &&
		(avs_address == 10'h3C2 || avs_address == 10'h3D5 || avs_address == 10'h3F3)
		|-> avs_readdata == 32'h0) else $error("reserved slot not zero");
	AST_STALL_SET: assert property (disable iff (sys_rst) fault_stall_set |=> fault_stalled_flag)
		else $error("stall not set");
	AST_STALL_CAUSE: assert property (disable iff (sys_rst)
		$rose(fault_stalled_flag) |-> $past(fault_stall_set)) else $error("stall from nothing");
	cover property (ats_req);
	cover property (pmu_irq);
	cover property (take && avs_read && avs_address == 10'h3C2);
endmodule
`default_nettype wire

// file: tb/scb_bank_bench.sv
/* self-checking bench for scb_bank: reset, window, reserved, ops, irq.
   assumes the checker file is compiled before this top. */
`default_nettype none
module scb_bank_bench;
	import scb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, ats_req, ats_done;
	logic tlb_sync_busy, fault_stall_set, ctx_ie, ctx_re, stalled, pmu_irq;
	logic [WADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [63:0] ats_addr;
	logic [7:0] pmu_events;
	scb_ats_kind_t ats_kind;
	int n_fail, checked;
	logic [11:0] rsvd [5] = '{OFF_PM_USER_SLOT, OFF_PM_SWINC_SLOT, OFF_PM_DEVTYPE_SLOT,
		12'h7F8, 12'h8F4};
	scb_bank i_scb_bank (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ats_req(ats_req), .ats_kind(ats_kind),
		.ats_addr(ats_addr), .ats_done(ats_done), .tlb_sync_busy(tlb_sync_busy),
		.fault_stall_set(fault_stall_set), .ctx_fault_irq_enable(ctx_ie),
		.ctx_fault_report_enable(ctx_re), .fault_stalled_flag(stalled),
		.pmu_events(pmu_events), .pmu_irq(pmu_irq));
	// ********************************************************
	// shared tasks
	// ********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		avs_address <= off[11:2];
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		n = 0;
		// settled value before the edge is what that edge samples
		do
		begin
			@(negedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0);
		chk(32'(n), 32'h2);
		@(posedge sys_clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] off, input logic [31:0] d);
		bus(1'b1, off, d);
	endtask
	task automatic rchk(input logic [11:0] off, input logic [31:0] e);
		bus(1'b0, off, 32'h0);
		chk(rd, e);
	endtask
	task automatic pulse_done();
		@(posedge sys_clk);
		ats_done <= 1'b1;
		@(posedge sys_clk);
		ats_done <= 1'b0;
	endtask
	// ********************************************************
	// scenarios
	// ********************************************************
	task automatic t_reset();
		tlb_sync_busy <= 1'b1;
		wr(OFF_CTX_CTRL, 32'h3);
		fault_stall_set <= 1'b1;
		@(posedge sys_clk);
		fault_stall_set <= 1'b0;
		rchk(OFF_CTX_CTRL, 32'h7);
		wr(OFF_CTX_CTRL, 32'h7);
		rchk(OFF_CTX_CTRL, 32'h3);
		fault_stall_set <= 1'b1;
		@(posedge sys_clk);
		fault_stall_set <= 1'b0;
		rchk(OFF_TLB_STATUS, 32'h1);
		wr(OFF_ATS_PRIV_RD, 32'h5);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		tlb_sync_busy <= 1'b0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		chk({29'h0, ctx_ie, ctx_re, stalled}, 32'h0);
		rchk(OFF_CTX_CTRL, 32'h0);
		rchk(OFF_ATS_STATUS, 32'h0);
		rchk(OFF_TLB_STATUS, 32'h0);
	endtask
	task automatic t_space();
		wr(OFF_IMPDEF_BASE, 32'hA5A5_0001);
		wr(12'hDF8, 32'h5A5A_00FF);
		rchk(OFF_IMPDEF_BASE, 32'hA5A5_0001);
		rchk(12'hDF8, 32'h5A5A_00FF);
		for (int i = 0; i < 5; i++)
		begin
			wr(rsvd[i], 32'hFFFF_FFFF);
			rchk(rsvd[i], 32'h0);
		end
	endtask
	task automatic t_ats();
		for (int k = 0; k < 4; k++)
		begin
			wr(OFF_ATS_PRIV_RD + 12'(k * 8), 32'h100 + k);
			@(negedge sys_clk);
			chk({29'h0, ats_kind, ats_req}, 32'(k * 2 + 1));
			chk(ats_addr[31:0], 32'h100 + k);
			chk(ats_addr[63:32], 32'h0);
			wr(OFF_ATS_USER_WR, 32'h1);
			@(negedge sys_clk);
			chk({31'h0, ats_req}, 32'h0);
			rchk(OFF_ATS_STATUS, 32'h1);
			pulse_done();
			rchk(OFF_ATS_STATUS, 32'h0);
		end
		wr(12'h804, 32'h1);
		rchk(OFF_ATS_STATUS, 32'h0);
	endtask
	task automatic t_irq();
		wr(OFF_PM_CTRL, 32'h1);
		wr(OFF_CNTEN_SET, 32'h1);
		wr(OFF_EVSEL_BASE, 32'h0);
		wr(OFF_EVCNT_BASE, 32'hFFFF_FFFF);
		@(posedge sys_clk);
		pmu_events <= 8'h01;
		@(posedge sys_clk);
		pmu_events <= 8'h00;
		rchk(OFF_EVCNT_BASE, 32'h0);
		rchk(OFF_OVS_SET, 32'h1);
		chk({31'h0, pmu_irq}, 32'h0);
		wr(OFF_INTEN_SET, 32'h1);
		@(negedge sys_clk);
		chk({31'h0, pmu_irq}, 32'h1);
		wr(OFF_INTEN_CLR, 32'h1);
		@(negedge sys_clk);
		chk({31'h0, pmu_irq}, 32'h0);
		wr(OFF_INTEN_SET, 32'h1);
		wr(OFF_OVS_CLR, 32'h1);
		@(negedge sys_clk);
		chk({31'h0, pmu_irq}, 32'h0);
		rchk(OFF_OVS_SET, 32'h0);
		rchk(OFF_PM_CFG, 32'h0000_1F0E);
		wr(OFF_EVCNT_BASE, 32'h0000_0005);
		rchk(OFF_EVCNT_BASE, 32'h0000_0005);
		wr(OFF_PM_CTRL, 32'h2);
		rchk(OFF_EVCNT_BASE, 32'h0);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (4000) @(posedge sys_clk);
		n_fail++;
		stop_test();
	end
	initial
	begin
		{sys_rst, avs_read, avs_write, ats_done, tlb_sync_busy, fault_stall_set} = 6'h20;
		{avs_address, avs_writedata, pmu_events} = '0;
		avs_byteenable = 4'hF;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_space();
		t_ats();
		t_irq();
		stop_test();
	end
endmodule
bind scb_bank scb_bank_checker i_scb_bank_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .ats_req(ats_req), .ats_kind(ats_kind),
	.ats_addr(ats_addr), .fault_stall_set(fault_stall_set),
	.fault_stalled_flag(fault_stalled_flag), .ctx_fault_irq_enable(ctx_fault_irq_enable),
	.ctx_fault_report_enable(ctx_fault_report_enable), .pmu_irq(pmu_irq));
`default_nettype wire
